// File: logic/tcp_pin_filter.sv
`default_nettype none

module tcp_pin_filter (
   input  wire logic mclk,
   input  wire logic sys_rst,
   input  wire logic pin,
   output var  logic level,
   output var  logic rise
);
   logic s1;
   logic s2;
   logic s3;

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
      end else begin
         s1 <= pin;
         s2 <= s1;
         s3 <= s2;
      end
   end

   // Level moves only when the last two stages agree
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         level <= 1'b0;
         rise  <= 1'b0;
      end else begin
         rise  <= (s2 == s3) && s2 && !level;
         if (s2 == s3) begin
            level <= s2;
         end
      end
   end
endmodule

`default_nettype wire

// File: logic/tcp_pkg.sv
// Functional notes
// R1 - Option bit 6 picks control register layout
// R2 - Emulation takes divide and source from option
// R3 - Request flag sets when count reaches zero
// R4 - Mask bit high blocks the timer interrupt
// R5 - Reset forces mask to one
// R6 - Source select one picks pin, zero internal
// R7 - Pin enable gates pin, emulation forces one
// R8 - Source and enable pick prescaler input clock
// R9 - Clear bit write-only, one pulses prescaler clear
// R10 - Emulation: clear bit reads one, no effect
// R11 - Divide select picks tap, one to 128
// R12 - Software writes clear with divide changes
// R13 - Programmable reset loads bits from option byte
// R14 - Count decrements per tick, CPU read/write
`default_nettype none

package tcp_pkg;
   localparam int          ADDR_W        = 11;
   localparam int          DATA_W        = 8;
   localparam int          DIV_W         = 3;
   localparam int          PRE_STAGES    = 7;

   // ----------------------------------------
   // Register map
   // ----------------------------------------
   localparam logic [10:0] ADDR_COUNT    = 11'h008;
   localparam logic [10:0] ADDR_CONTROL  = 11'h009;
   localparam logic [10:0] ADDR_OPTION   = 11'h784;

   // ----------------------------------------
   // Control and option bit positions
   // ----------------------------------------
   localparam int          BIT_REQ       = 7;
   localparam int          BIT_MASK      = 6;
   localparam int          BIT_SRC       = 5;
   localparam int          BIT_PIN_EN    = 4;
   localparam int          BIT_CLEAR     = 3;
   localparam int          DIV_LSB       = 0;
   localparam int          OPT_EMU       = 6;
   localparam int          OPT_SRC       = 5;
   localparam int          OPT_PIN_EN    = 4;

   localparam logic [5:0]  EMU_LOW_READ  = 6'h3f;
   localparam logic [7:0]  COUNT_ONE     = 8'h01;
   localparam logic [7:0]  COUNT_ZERO    = 8'h00;
   localparam logic [7:0]  READ_UNMAPPED = 8'h00;

   // Source select and pin enable, in that order
   localparam logic [1:0]  CLK_INTERNAL  = 2'h0;
   localparam logic [1:0]  CLK_GATED     = 2'h1;
   localparam logic [1:0]  CLK_NONE      = 2'h2;
   localparam logic [1:0]  CLK_PIN       = 2'h3;
endpackage

`default_nettype wire

// File: logic/tcp_pre_if.sv
`default_nettype none

interface tcp_pre_if;
   import tcp_pkg::*;
   logic              tick_in;
   logic              clear;
   logic [DIV_W-1:0]  divide;
   logic              tick_out;

   modport ctrl (output tick_in, output clear, output divide, input tick_out);
   modport pre  (input tick_in, input clear, input divide, output tick_out);
endinterface

`default_nettype wire

// File: logic/tcp_prescaler.sv
`default_nettype none

module tcp_prescaler #(
   parameter int STAGES = tcp_pkg::PRE_STAGES
) (
   input  wire logic mclk,
   input  wire logic sys_rst,
   tcp_pre_if.pre    bus
);
   import tcp_pkg::*;

   if (STAGES < PRE_STAGES || STAGES > 31) begin : g_stage_check
      $error("prescaler needs at least seven stages");
   end

   logic [STAGES-1:0] stage;

   function automatic logic [STAGES-1:0] tap_mask(input logic [DIV_W-1:0] sel);
      tap_mask = STAGES'((1 << sel) - 1);
   endfunction

   always_ff @(posedge mclk) begin
      if (sys_rst || bus.clear) begin
         stage <= '0;
      end else if (bus.tick_in) begin
         stage <= stage + STAGES'(1);
      end
   end

   // Tap n passes every 2**n input ticks; code 0 bypasses
   assign bus.tick_out = bus.tick_in && !bus.clear &&
                         ((stage & tap_mask(bus.divide)) == tap_mask(bus.divide)); // R11
endmodule

`default_nettype wire

// File: logic/tcp_timer.sv
`default_nettype none

module tcp_timer #(
   parameter int COUNT_W = 8
) (
   input  wire logic                      mclk,
   input  wire logic                      sys_rst,
   input  wire logic [tcp_pkg::ADDR_W-1:0] cpu_addr,
   input  wire logic                      cpu_wr,
   input  wire logic                      cpu_rd,
   input  wire logic [tcp_pkg::DATA_W-1:0] cpu_wdata,
   output var  logic [tcp_pkg::DATA_W-1:0] cpu_rdata,
   input  wire logic [tcp_pkg::DATA_W-1:0] option_byte,
   input  wire logic                      timer_pin,
   output logic                           timer_irq
);
   import tcp_pkg::*;

   if (COUNT_W != DATA_W) begin : g_width_check
      $error("count width must match the data bus");
   end

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   logic [DATA_W-1:0] timer_count;
   logic [DATA_W-1:0] option_latch;
   logic              emulation_select;
   logic              underflow_request;
   logic              request_mask;
   logic              source_select;
   logic              pin_enable;
   logic [DIV_W-1:0]  divide_select;

   logic              pin_level;
   logic              pin_rise;
   logic              eff_source;
   logic              eff_pin_en;
   logic [DIV_W-1:0]  eff_divide;
   logic              wr_count;
   logic              wr_control;
   logic              count_tick;
   logic              reaches_zero;
   logic [DATA_W-1:0] control_view;

   tcp_pre_if pre_bus ();

   tcp_pin_filter u_pin (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .pin     (timer_pin),
      .level   (pin_level),
      .rise    (pin_rise)
   );

   tcp_prescaler #(
      .STAGES (PRE_STAGES)
   ) u_pre (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .bus     (pre_bus.pre)
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] target);
      hit = (a == target);
   endfunction

   assign wr_control = cpu_wr && hit(cpu_addr, ADDR_CONTROL);
   assign wr_count   = cpu_wr && hit(cpu_addr, ADDR_COUNT);

   // ----------------------------------------
   // Option byte and layout select
   // ----------------------------------------
   // The option byte is EPROM content; it is taken once at reset
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         option_latch     <= option_byte;
         emulation_select <= option_byte[OPT_EMU]; // R1
      end
   end

   // Emulation takes source and divide from the option byte
   assign eff_source = emulation_select ? option_latch[OPT_SRC] : source_select;             // R2 R6
   assign eff_pin_en = emulation_select ? 1'b1 : pin_enable;                                 // R7
   assign eff_divide = emulation_select ? option_latch[DIV_LSB +: DIV_W] : divide_select;    // R2 R11

   // ----------------------------------------
   // Software-programmable control fields
   // ----------------------------------------
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         source_select <= option_byte[OPT_SRC];                // R13
         pin_enable    <= option_byte[OPT_PIN_EN];             // R13
         divide_select <= option_byte[DIV_LSB +: DIV_W];       // R13
      end else if (wr_control && !emulation_select) begin
         source_select <= cpu_wdata[BIT_SRC];
         pin_enable    <= cpu_wdata[BIT_PIN_EN];
         divide_select <= cpu_wdata[DIV_LSB +: DIV_W];
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         request_mask <= 1'b1;                                 // R5
      end else if (wr_control) begin
         request_mask <= cpu_wdata[BIT_MASK];
      end
   end

   // ----------------------------------------
   // Prescaler input selection
   // ----------------------------------------
   // Internal clock is the phase clock itself, one tick per mclk
   always_comb begin
      case ({eff_source, eff_pin_en})                          // R8
         CLK_INTERNAL: pre_bus.tick_in = 1'b1;
         CLK_GATED:    pre_bus.tick_in = pin_level;
         CLK_NONE:     pre_bus.tick_in = 1'b0;
         CLK_PIN:      pre_bus.tick_in = pin_rise;
         default:      pre_bus.tick_in = 1'b0;
      endcase
   end

   // A clear in the same write as a divide change avoids a stray count
   assign pre_bus.clear  = wr_control && cpu_wdata[BIT_CLEAR] && !emulation_select; // R9 R10 R12
   assign pre_bus.divide = eff_divide;
   assign count_tick     = pre_bus.tick_out;

   // ----------------------------------------
   // Count register and underflow request
   // ----------------------------------------
   assign reaches_zero = count_tick && !wr_count && (timer_count == COUNT_ONE);

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         timer_count <= COUNT_ZERO;
      end else if (wr_count) begin
         timer_count <= cpu_wdata;                             // R14
      end else if (count_tick) begin
         timer_count <= timer_count - COUNT_ONE;               // R14
      end
   end

   // Hardware set wins over a software clear in the same cycle
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         underflow_request <= 1'b0;                            // R3
      end else if (reaches_zero) begin
         underflow_request <= 1'b1;                            // R3
      end else if (wr_control) begin
         underflow_request <= cpu_wdata[BIT_REQ];
      end
   end

   assign timer_irq = underflow_request && !request_mask;      // R4

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      if (emulation_select) begin
         control_view = {underflow_request, request_mask, EMU_LOW_READ};          // R1 R10
      end else begin
         control_view = {underflow_request, request_mask, source_select, pin_enable,
                         1'b0, divide_select};                                     // R1 R9
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cpu_rdata <= READ_UNMAPPED;
      end else if (cpu_rd) begin
         case (cpu_addr)
            ADDR_COUNT:   cpu_rdata <= timer_count;              // R14
            ADDR_CONTROL: cpu_rdata <= control_view;
            ADDR_OPTION:  cpu_rdata <= option_latch;
            default:      cpu_rdata <= READ_UNMAPPED;
         endcase
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   sequence s_ctrl_read;
      cpu_rd && !cpu_wr && hit(cpu_addr, ADDR_CONTROL);
   endsequence

   sequence s_ctrl_write;
      cpu_wr && hit(cpu_addr, ADDR_CONTROL);
   endsequence

   sequence s_count_write;
      cpu_wr && hit(cpu_addr, ADDR_COUNT);
   endsequence

   sequence s_hw_set;
      reaches_zero;
   endsequence

   // ----------------------------------------
   // Control layout and prescaler clear
   // ----------------------------------------
   a_layout_emu: assert property (s_ctrl_read ##0 emulation_select |=> cpu_rdata[5:0] == EMU_LOW_READ) // R1
      else $error("emulation layout low bits not all ones");

   a_clear_reads_zero: assert property (s_ctrl_read ##0 !emulation_select |=> !cpu_rdata[BIT_CLEAR]) // R9
      else $error("clear bit did not read zero");

   a_req_visible: assert property (s_ctrl_read |=> cpu_rdata[BIT_REQ] == $past(underflow_request)) // R1
      else $error("request bit missing from control view");

   a_clear_pulse: assert property (s_ctrl_write ##0 (cpu_wdata[BIT_CLEAR] && !emulation_select) // R9
                                   |-> pre_bus.clear ##1 (!pre_bus.clear || wr_control))
      else $error("clear pulse missing or stuck");

   a_clear_no_tick: assert property (pre_bus.clear |-> !count_tick) // R9
      else $error("tick passed during prescaler clear");

   a_emu_no_clear: assert property (emulation_select |-> !pre_bus.clear) // R10
      else $error("clear acted in emulation");

   // ----------------------------------------
   // Request and mask
   // ----------------------------------------
   a_req_on_zero: assert property (s_hw_set |=> underflow_request && timer_count == COUNT_ZERO) // R3
      else $error("request not set at zero");

   // Set wins, so a clear that meets an underflow leaves the request up
   a_req_set_wins: assert property (s_hw_set and s_ctrl_write |=> underflow_request) // R3
      else $error("software clear beat the underflow");

   a_req_sw_clear: assert property (s_ctrl_write ##0 (!cpu_wdata[BIT_REQ] && !reaches_zero) // R3
                                    |=> !underflow_request)
      else $error("software clear ignored");

   a_req_holds: assert property (underflow_request && !wr_control |=> underflow_request) // R3
      else $error("request dropped on its own");

   a_mask_blocks: assert property (request_mask |-> !timer_irq) // R4
      else $error("masked request reached processor");

   a_irq_level: assert property (timer_irq |-> underflow_request) // R4
      else $error("interrupt without a request");

   a_irq_follow: assert property (underflow_request && !request_mask && !wr_control |=> timer_irq) // R4
      else $error("unmasked request not forwarded");

   a_mask_reset: assert property ($fell(sys_rst) |-> request_mask) // R5
      else $error("mask not set by reset");

   a_mask_clear: assert property (s_ctrl_write ##0 !cpu_wdata[BIT_MASK] |=> !request_mask) // R5
      else $error("mask not cleared by software");

   a_mask_set: assert property (s_ctrl_write ##0 cpu_wdata[BIT_MASK] |=> request_mask) // R5
      else $error("mask not set by software");

   // ----------------------------------------
   // Clock selection
   // ----------------------------------------
   a_internal_clock: assert property ({eff_source, eff_pin_en} == CLK_INTERNAL |-> pre_bus.tick_in) // R6 R8
      else $error("internal clock not passed");

   a_gated_clock: assert property ({eff_source, eff_pin_en} == CLK_GATED |-> pre_bus.tick_in == pin_level) // R8
      else $error("gated clock not following the pin");

   a_pin_clock: assert property ({eff_source, eff_pin_en} == CLK_PIN |-> pre_bus.tick_in == pin_rise) // R6 R8
      else $error("event clock not following pin edges");

   a_no_clock: assert property ({eff_source, eff_pin_en} == CLK_NONE && !wr_control |-> !count_tick [*2]) // R8
      else $error("tick with no clock selected");

   a_emu_divide: assert property (emulation_select |-> eff_divide == option_latch[DIV_LSB +: DIV_W] && eff_pin_en) // R2
      else $error("emulation settings not from option byte");

   a_emu_source: assert property (emulation_select |-> eff_source == option_latch[OPT_SRC]) // R2
      else $error("emulation source not from option byte");

   a_reset_load: assert property ($fell(sys_rst) && !emulation_select // R13
                                  |-> divide_select == option_latch[DIV_LSB +: DIV_W] &&
                                      source_select == option_latch[OPT_SRC] &&
                                      pin_enable == option_latch[OPT_PIN_EN])
      else $error("control fields not loaded from option byte");

   // ----------------------------------------
   // Count register
   // ----------------------------------------
   a_count_dec: assert property (count_tick && !wr_count |=> timer_count == $past(timer_count) - COUNT_ONE) // R14
      else $error("count did not decrement");

   a_count_write: assert property (s_count_write |=> timer_count == $past(cpu_wdata)) // R14
      else $error("count write lost");

   a_count_hold: assert property (!count_tick && !wr_count |=> $stable(timer_count)) // R14
      else $error("count moved without a tick");

   a_tap_bypass: assert property (eff_divide == '0 && !pre_bus.clear |-> count_tick == pre_bus.tick_in) // R11
      else $error("bypass code did not pass every tick");
endmodule

`default_nettype wire

// File: testbench/tcp_pin_model.sv
`default_nettype none

// ------------------------------------------------------------
// External event source on the timer pin
// ------------------------------------------------------------
module tcp_pin_model (
   input  wire logic mclk,
   output var  logic timer_pin
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      timer_pin = 1'b0;
   end

   // High is held hi cycles and low 5 cycles between pulses so the 3-flop synchroniser always sees each level
   task automatic pulses(input int n, input int hi);
      repeat (n) begin
         @(posedge mclk);
         timer_pin <= 1'b1;
         repeat (hi) @(posedge mclk);
         timer_pin <= 1'b0;
         repeat (4) @(posedge mclk);
      end
   endtask
endmodule

`default_nettype wire

// File: testbench/timer_control_prescaler_bench.sv
`default_nettype none

module timer_control_prescaler_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import tcp_pkg::*;

   logic              mclk = 1'b0;
   logic              sys_rst = 1'b1;
   logic [ADDR_W-1:0] cpu_addr = '0;
   logic              cpu_wr = 1'b0;
   logic              cpu_rd = 1'b0;
   logic [DATA_W-1:0] cpu_wdata = '0;
   logic [DATA_W-1:0] cpu_rdata;
   logic [DATA_W-1:0] option_byte = 8'h37;
   logic              timer_irq;
   logic              timer_pin;
   logic [7:0]        exp_q[$];
   logic [7:0]        tol_q[$];
   logic              pend = 1'b0;
   logic [7:0]        rnd;
   int                seed = 32'hc4b10693;
   int                failures = 0;
   int                checked = 0;

   tcp_pin_model pin_model_i (
      .mclk      (mclk),
      .timer_pin (timer_pin)
   );

   tcp_timer tcp_timer_i (
      .mclk        (mclk),
      .sys_rst     (sys_rst),
      .cpu_addr    (cpu_addr),
      .cpu_wr      (cpu_wr),
      .cpu_rd      (cpu_rd),
      .cpu_wdata   (cpu_wdata),
      .cpu_rdata   (cpu_rdata),
      .option_byte (option_byte),
      .timer_pin   (timer_pin),
      .timer_irq   (timer_irq)
   );

   initial begin
      forever #4 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // Bus tasks
   // ------------------------------------------------------------
   task automatic rst(input logic [7:0] opt);
      @(posedge mclk);
      sys_rst <= 1'b1;
      option_byte <= opt;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
   endtask

   task automatic wr(input logic [10:0] a, input logic [7:0] d);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_wdata <= d;
      cpu_wr <= 1'b1;
      @(posedge mclk);
      cpu_wr <= 1'b0;
   endtask

   // Tolerance lets the tick phase against the read edge vary a little
   task automatic rd(input logic [10:0] a, input logic [7:0] e, input logic [7:0] t);
      @(posedge mclk);
      cpu_addr <= a;
      cpu_rd <= 1'b1;
      exp_q.push_back(e);
      tol_q.push_back(t);
      @(posedge mclk);
      cpu_rd <= 1'b0;
   endtask

   // Look between edges, once the last write has settled
   task automatic chk_irq(input logic e);
      @(negedge mclk);
      checked++;
      if (timer_irq !== e) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, timer_irq, e);
      end
   endtask

   // ------------------------------------------------------------
   // Read-data monitor
   // ------------------------------------------------------------
   always @(posedge mclk) begin
      logic [7:0] e;
      logic [7:0] t;
      if (pend) begin
         e = exp_q.pop_front();
         t = tol_q.pop_front();
         checked++;
         if ($isunknown(cpu_rdata) || !((e - cpu_rdata) <= t)) begin
            failures++;
            $display("ERROR t=%0t got=%h exp=%h", $time, cpu_rdata, e);
         end
      end
      pend <= cpu_rd;
   end

   task automatic tally_and_finish;
      if (failures == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      repeat (30000) @(posedge mclk);
      failures++;
      tally_and_finish();
   end

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   initial begin
      rst(8'h37);
      rd(ADDR_CONTROL, 8'h77, 8'h00);
      rd(ADDR_OPTION, 8'h37, 8'h00);
      rd(11'h00a, 8'h00, 8'h00);
      chk_irq(1'b0);
      // Underflow with the request unmasked
      wr(ADDR_CONTROL, 8'h08);
      wr(ADDR_COUNT, 8'h05);
      repeat (20) @(posedge mclk);
      rd(ADDR_CONTROL, 8'h80, 8'h00);
      chk_irq(1'b1);
      wr(ADDR_CONTROL, 8'hc0);
      chk_irq(1'b0);
      wr(ADDR_CONTROL, 8'h40);
      rd(ADDR_CONTROL, 8'h40, 8'h00);
      // Every divide tap, clear written with each change
      for (int d = 0; d < 8; d++) begin
         wr(ADDR_CONTROL, 8'h48 | 8'(d));
         wr(ADDR_COUNT, 8'hff);
         repeat (200) @(posedge mclk);
         rd(ADDR_COUNT, 8'hff - 8'(200 >> d), 8'h03);
      end
      // Source off: count holds a random value
      rnd = 8'($random(seed));
      wr(ADDR_CONTROL, 8'h68);
      wr(ADDR_COUNT, rnd);
      repeat (50) @(posedge mclk);
      rd(ADDR_COUNT, rnd, 8'h00);
      // Gated with the pin low: no ticks
      wr(ADDR_CONTROL, 8'h58);
      wr(ADDR_COUNT, rnd);
      repeat (50) @(posedge mclk);
      rd(ADDR_COUNT, rnd, 8'h00);
      // Gated with the pin high for 40 cycles
      pin_model_i.pulses(1, 40);
      rd(ADDR_COUNT, rnd - 8'd40, 8'h04);
      // Event counting on pin edges
      wr(ADDR_CONTROL, 8'h78);
      wr(ADDR_COUNT, 8'h20);
      pin_model_i.pulses(5, 4);
      repeat (8) @(posedge mclk);
      rd(ADDR_COUNT, 8'h1b, 8'h00);
      // Emulation layout
      rst(8'h47);
      rd(ADDR_CONTROL, 8'h7f, 8'h00);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_CONTROL, 8'h3f, 8'h00);
      wr(ADDR_COUNT, 8'hff);
      // Emulation forces the pin enable, so the internal clock is gated by the pin
      pin_model_i.pulses(1, 300);
      rd(ADDR_COUNT, 8'hff - 8'(300 / 128), 8'h00);
      repeat (4) @(posedge mclk);
      tally_and_finish();
   end
endmodule

`default_nettype wire
